//--- src/usp_pkg.sv
// Purpose: Constants shared by the serial port control block
// Assumes: 8-bit register port, 100 MHz clock, external bit-rate tick at 16x bit rate
// Notes: Register offsets are local indices on the plain register port
package usp_pkg;
	// Register offsets
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_DATA = 3'h1;
	localparam logic [2:0] ADDR_IRQ_STATUS = 3'h2;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
	// Control register field positions
	localparam int BIT_FORMAT = 7;
	localparam int BIT_RESERVED = 6;
	localparam int BIT_MCE = 5;
	localparam int BIT_RX_EN = 4;
	localparam int BIT_TX9 = 3;
	localparam int BIT_RX9 = 2;
	localparam int BIT_TX_DONE = 1;
	localparam int BIT_RX_DONE = 0;
	// Control register reset value (reserved bit reads one)
	localparam logic [7:0] CONTROL_RESET = 8'h40;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// Interrupt status layout
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// Oversampling: ticks per bit and centre sample point
	localparam logic [3:0] TICKS_PER_BIT = 4'hF;
	localparam logic [3:0] TICK_CENTRE = 4'h7;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	// Shared state encoding
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_STOP = 3'b011,
		ST_DONE = 3'b100
	} usp_state_e;
endpackage : usp_pkg

//--- src/usp_serial_port.sv
// Purpose: Control, status and shift logic of an asynchronous serial port
// Assumes: tick_i pulses at 16x the bit rate, register port reads with one cycle latency
// Notes: Frame is start, 8 data LSB first, optional ninth bit, stop
//
// Chosen here: strobed register access and the address map.
module usp_serial_port (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Bit-rate tick from timer overflow
	input wire logic tick_i,
	// Register port
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Serial pins
	input wire logic rx_i,
	output logic tx_o,
	// Interrupt and status
	output logic irq_o,
	output logic tx_busy_o
);
	import usp_pkg::*;

	// Control fields
	logic frame_format_select;
	logic multidrop_check_enable;
	logic rx_enable;
	logic tx_ninth_bit;
	logic rx_ninth_bit;
	logic tx_done_flag;
	logic rx_done_flag;
	logic [7:0] rx_latch;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	// Register map on the plain port, one byte per address:
	// Address 0 holds the control fields and both done flags
	// Address 1 writes start a transmit frame, reads return the receive latch
	// Address 2 is the sticky event status, write one to clear
	// Address 3 is the event mask, same layout as the status
	// Reads land one cycle after the strobe and read zero otherwise,
	// so a bus that ORs several slaves needs no extra gating.
	// The port never stalls the master; every access takes one cycle.

	// Register decode
	logic wr_ctrl, wr_data, wr_stat, wr_mask;
	assign wr_ctrl = wr_i && (addr_i == ADDR_CONTROL);
	assign wr_data = wr_i && (addr_i == ADDR_DATA);
	assign wr_stat = wr_i && (addr_i == ADDR_IRQ_STATUS);
	assign wr_mask = wr_i && (addr_i == ADDR_IRQ_MASK);

	// Transmit state
	usp_state_e tx_state;
	logic [3:0] tx_tick_cnt;
	logic [3:0] tx_bit_cnt;
	logic [8:0] tx_shift;
	logic tx_set_done;

	// Receive state
	usp_state_e rx_state;
	logic [3:0] rx_tick_cnt;
	logic [3:0] rx_bit_cnt;
	logic [8:0] rx_shift;
	logic rx_accept;
	logic rx_checked;

	// Three-stage synchroniser on the receive pin; only stages 2 and 3 are read
	// The filtered level lags the pin by three to four cycles, far below
	// one bit, so the centre sample point is not disturbed.
	logic rx_s1, rx_s2, rx_s3, rx_level;
	// Previous filtered level; resets to the idle level so no false edge follows reset
	logic rx_prev;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_level <= 1'b1;
			rx_prev <= 1'b1;
		end else if (clk_en_i) begin
			rx_s1 <= rx_i;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			rx_prev <= rx_level;
			if (rx_s2 == rx_s3) begin
				rx_level <= rx_s3; // Change counts once stages agree
			end
		end
	end

	// Control register; reserved bit held at its reset value
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			frame_format_select <= 1'b0;
			multidrop_check_enable <= 1'b0;
			rx_enable <= 1'b0;
			tx_ninth_bit <= 1'b0;
		end else if (clk_en_i && wr_ctrl) begin
			frame_format_select <= wdata_i[BIT_FORMAT];
			multidrop_check_enable <= wdata_i[BIT_MCE];
			rx_enable <= wdata_i[BIT_RX_EN];
			tx_ninth_bit <= wdata_i[BIT_TX9];
		end
	end

	// Transmit done flag: hardware set wins over a software write
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_done_flag <= 1'b0;
		end else if (clk_en_i) begin
			if (tx_set_done) begin
				tx_done_flag <= 1'b1;
			end else if (wr_ctrl) begin
				tx_done_flag <= wdata_i[BIT_TX_DONE];
			end
		end
	end

	// Receive done flag, ninth bit and latch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_done_flag <= 1'b0;
			rx_ninth_bit <= 1'b0;
			rx_latch <= DATA_RESET;
		end else if (clk_en_i) begin
			if (rx_accept) begin
				rx_done_flag <= 1'b1;
				rx_ninth_bit <= rx_checked;
				rx_latch <= rx_shift[7:0];
			end else if (wr_ctrl) begin
				rx_done_flag <= wdata_i[BIT_RX_DONE];
				rx_ninth_bit <= wdata_i[BIT_RX9];
			end
		end
	end

	// Interrupt status: set wins over write-one-to-clear
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
		end else if (clk_en_i) begin
			irq_status[IRQ_TX] <= tx_set_done | (irq_status[IRQ_TX] & ~(wr_stat & wdata_i[IRQ_TX]));
			irq_status[IRQ_RX] <= rx_accept | (irq_status[IRQ_RX] & ~(wr_stat & wdata_i[IRQ_RX]));
			if (wr_mask) begin
				irq_mask <= wdata_i[1:0];
			end
		end
	end

	// Pending request while a status bit or the transmit done flag is still up and its source is enabled
	assign irq_o = |(irq_status & irq_mask) | (tx_done_flag & irq_mask[IRQ_TX]);

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o <= DATA_RESET;
		end else if (clk_en_i) begin
			rdata_o <= DATA_RESET;
			if (rd_i) begin
				case (addr_i)
					ADDR_CONTROL: rdata_o <= {frame_format_select, CONTROL_RESET[BIT_RESERVED],
						multidrop_check_enable, rx_enable, tx_ninth_bit, rx_ninth_bit,
						tx_done_flag, rx_done_flag};
					ADDR_DATA: rdata_o <= rx_latch;
					ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_status};
					ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
					default: rdata_o <= DATA_RESET;
				endcase
			end
		end
	end

	// Transmit timing, counted in ticks of the external bit-rate tick:
	// The start bit goes out the cycle after the data write, before any tick,
	// so the first bit may be up to one tick shorter than sixteen.
	// Each data bit then stands for a full sixteen ticks.
	// The done flag rises as the stop bit begins in both formats; in the
	// eight-bit format that is the moment the eighth data bit ends.
	// Busy stays high through the stop bit so a new write cannot clip it.
	// The ninth bit is captured with the byte, so changing the control
	// during a frame does not alter the ninth bit already on the line.
	// Transmitter; a write during a frame is ignored, software waits for the flag
	assign tx_busy_o = (tx_state != ST_IDLE);
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_state <= ST_IDLE;
			tx_tick_cnt <= COUNT_ZERO;
			tx_bit_cnt <= COUNT_ZERO;
			tx_shift <= 9'h1FF;
			tx_o <= 1'b1;
			tx_set_done <= 1'b0;
		end else if (clk_en_i) begin
			tx_set_done <= 1'b0;
			case (tx_state)
				ST_IDLE: begin
					tx_o <= 1'b1;
					if (wr_data) begin
						tx_shift <= {tx_ninth_bit, wdata_i};
						tx_state <= ST_START;
						tx_tick_cnt <= COUNT_ZERO;
						tx_o <= 1'b0;
					end
				end
				ST_START: begin
					if (tick_i) begin
						tx_tick_cnt <= tx_tick_cnt + 4'h1;
						if (tx_tick_cnt == TICKS_PER_BIT) begin
							tx_state <= ST_DATA;
							tx_bit_cnt <= COUNT_ZERO;
							tx_o <= tx_shift[0];
						end
					end
				end
				ST_DATA: begin
					if (tick_i) begin
						tx_tick_cnt <= tx_tick_cnt + 4'h1;
						if (tx_tick_cnt == TICKS_PER_BIT) begin
							tx_bit_cnt <= tx_bit_cnt + 4'h1;
							tx_shift <= {1'b1, tx_shift[8:1]};
							// Nine-bit sends one more bit; eight-bit ignores the ninth
							if (tx_bit_cnt == (frame_format_select ? BITS_8 : BITS_8 - 4'h1)) begin
								tx_state <= ST_STOP;
								tx_o <= 1'b1;
								tx_set_done <= 1'b1;
							end else begin
								tx_o <= tx_shift[1];
							end
						end
					end
				end
				ST_STOP: begin
					if (tick_i) begin
						tx_tick_cnt <= tx_tick_cnt + 4'h1;
						if (tx_tick_cnt == TICKS_PER_BIT) begin
							tx_state <= ST_IDLE;
						end
					end
				end
				default: tx_state <= ST_IDLE;
			endcase
		end
	end

	// Receive timing:
	// A frame starts only on a falling edge of the filtered line. A plain
	// low level is not enough: a frame whose stop bit is low leaves the line
	// low after the stop sample, and a level test would take that tail for
	// a new start bit and shift in a phantom byte of zeros.
	// Half a bit after the edge the start bit is checked again; a high
	// level there is a glitch and the receiver returns to idle.
	// Every later sample sits a whole bit after the previous one, at the
	// centre of the bit, which tolerates drift of almost half a bit.
	// The accept decision is made one cycle after the stop sample, when
	// the checked bit has settled in its own register.
	// Receiver: start on falling edge, sample at bit centre
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_state <= ST_IDLE;
			rx_tick_cnt <= COUNT_ZERO;
			rx_bit_cnt <= COUNT_ZERO;
			rx_shift <= 9'h000;
			rx_accept <= 1'b0;
			rx_checked <= 1'b0;
		end else if (clk_en_i) begin
			rx_accept <= 1'b0;
			case (rx_state)
				ST_IDLE: begin
					if (rx_enable && rx_prev && !rx_level) begin
						rx_state <= ST_START;
						rx_tick_cnt <= COUNT_ZERO;
					end
				end
				ST_START: begin
					if (tick_i) begin
						rx_tick_cnt <= rx_tick_cnt + 4'h1;
						if (rx_tick_cnt == TICK_CENTRE) begin
							// False start on a glitch returns to idle
							rx_state <= rx_level ? ST_IDLE : ST_DATA;
							rx_tick_cnt <= COUNT_ZERO;
							rx_bit_cnt <= COUNT_ZERO;
						end
					end
				end
				ST_DATA: begin
					if (tick_i) begin
						rx_tick_cnt <= rx_tick_cnt + 4'h1;
						if (rx_tick_cnt == TICKS_PER_BIT) begin
							rx_bit_cnt <= rx_bit_cnt + 4'h1;
							rx_shift[rx_bit_cnt] <= rx_level;
							if (rx_bit_cnt == (frame_format_select ? BITS_8 : BITS_8 - 4'h1)) begin
								rx_state <= ST_STOP;
							end
						end
					end
				end
				ST_STOP: begin
					if (tick_i) begin
						rx_tick_cnt <= rx_tick_cnt + 4'h1;
						if (rx_tick_cnt == TICKS_PER_BIT) begin
							rx_state <= ST_DONE;
							// Eight-bit checks stop, nine-bit checks ninth
							rx_checked <= frame_format_select ? rx_shift[8] : rx_level;
						end
					end
				end
				ST_DONE: begin
					rx_state <= ST_IDLE;
					// Overrun: keep first byte while the flag is set
					rx_accept <= !rx_done_flag && (!multidrop_check_enable || rx_checked);
				end
				default: rx_state <= ST_IDLE;
			endcase
		end
	end
endmodule : usp_serial_port

//--- verif/usp_serial_port_props.sv
// Purpose: Port checks for the serial port block
// Assumes: One clock, reset high
// Notes: Bound to the serial port module
module usp_props
	import usp_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Pins
	input wire logic tx_o,
	input wire logic irq_o,
	input wire logic tx_busy_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Read data stands only after a read
	property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_map; rd_i && addr_i > ADDR_IRQ_MASK |=> rdata_o == 8'h00; endproperty
	a_rd_map: assert property (p_rd_map) else $error("unmapped read");
	property p_rd_res; rd_i && addr_i == ADDR_CONTROL |=> rdata_o[BIT_RESERVED]; endproperty
	a_rd_res: assert property (p_rd_res) else $error("reserved bit low");
	// Framing; a late write must not cut a frame short
	property p_tx_go; wr_i && addr_i == ADDR_DATA && !tx_busy_o |=> tx_busy_o && !tx_o; endproperty
	a_tx_go: assert property (p_tx_go) else $error("no start bit");
	property p_tx_start; $rose(tx_busy_o) |-> (!tx_o) [*8]; endproperty
	a_tx_start: assert property (p_tx_start) else $error("short start bit");
	property p_tx_stop; $fell(tx_busy_o) |-> $past(tx_o, 8) && tx_o; endproperty
	a_tx_stop: assert property (p_tx_stop) else $error("bad stop bit");
	property p_tx_hold; tx_busy_o && wr_i && addr_i == ADDR_DATA |=> tx_busy_o; endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("frame cut");
	property p_irq_off; wr_i && addr_i == ADDR_IRQ_MASK && wdata_i[1:0] == 2'h0 |=> !irq_o; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq high");
	c_tx: cover property ($fell(tx_busy_o));
	c_irq: cover property ($rose(irq_o));
	c_rd: cover property (rd_i && addr_i == ADDR_DATA);
endmodule : usp_props

bind usp_serial_port usp_props u_props (.*);

//--- verif/usp_peer.sv
// Purpose: Far serial node on the two pins
// Assumes: BITC clock cycles per bit
// Notes: Line idles high like a pulled-up pin
module usp_peer #(
	parameter int BITC = 32
) (
	// Clock
	input wire logic clock_i,
	// Send side, bits in line order
	input wire logic go_i,
	input wire logic [10:0] frame_i,
	input wire logic [3:0] len_i,
	output logic busy_o,
	output logic rx_o,
	// Receive side
	input wire logic tx_i,
	input wire logic nine_i,
	output logic got_o,
	output logic [9:0] word_o
);
	// Sender, start and stop come with the frame
	initial begin
		rx_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge clock_i);
			if (go_i) begin
				busy_o <= 1'b1;
				for (int i = 0; i < len_i; i++) begin
					rx_o <= frame_i[i];
					repeat (BITC) @(posedge clock_i);
				end
				rx_o <= 1'b1;
				busy_o <= 1'b0;
			end
		end
	end
	// Receiver, centre sampled so edge jitter does not matter
	initial begin
		got_o = 1'b0;
		forever begin
			@(posedge clock_i);
			got_o <= 1'b0;
			if (tx_i === 1'b0) begin
				word_o <= 10'h3FF;
				repeat (BITC / 2) @(posedge clock_i);
				for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
					repeat (BITC) @(posedge clock_i);
					word_o[i] <= tx_i;
				end
				got_o <= 1'b1;
			end
		end
	end
endmodule : usp_peer

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the serial port block
// Assumes: Tick every second cycle, so a bit is 32 cycles
// Notes: Reads and peer frames are checked against queued notes
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h", $time, a); end end
module tb_top
	import usp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0, rst_i = 1'b1, tick_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, go = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, d, latch = 8'h00;
	logic [10:0] frame = 11'h7FF;
	logic [3:0] len = 4'h0;
	logic [9:0] word;
	logic rx, tx_o, irq_o, tx_busy_o, busy, got, nine = 1'b0, flag, r9, acc;
	logic [4:0] c;
	logic [4:0] cases [9] = '{5'h09, 5'h18, 5'h0A, 5'h08, 5'h0E, 5'h0F, 5'h0C, 5'h05, 5'h0B};
	logic [7:0] rd_q [$];
	logic [9:0] fr_q [$];
	int tests_run = 0, miscompares = 0, seed = 55675, n;
	always #5 clock_i = ~clock_i;
	// Bit-rate tick
	always @(posedge clock_i) tick_i <= ~tick_i;
	usp_serial_port u_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(1'b1), .tick_i(tick_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx), .tx_o(tx_o), .irq_o(irq_o),
		.tx_busy_o(tx_busy_o));
	usp_peer u_peer (.clock_i(clock_i), .go_i(go), .frame_i(frame), .len_i(len), .busy_o(busy), .rx_o(rx),
		.tx_i(tx_o), .nine_i(nine), .got_o(got), .word_o(word));
	// Oldest note against each result
	always @(posedge clock_i) begin
		rd_d <= rd_i;
		if (rd_d) `CHK(rdata_o, rd_q.pop_front())
		if (got) `CHK(word, fr_q.pop_front())
	end
	task automatic results();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// One bus cycle; v is write data or expected read data
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= v;
		if (!w) rd_q.push_back(v);
		@(posedge clock_i);
	endtask : bus
	task automatic idle(input int k);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		repeat (k) @(posedge clock_i);
	endtask : idle
	task automatic await(ref logic s, input logic v);
		n = 0;
		while (s !== v) begin
			@(posedge clock_i);
			n++;
			if (n > 2000) begin
				miscompares++;
				results();
			end
		end
	endtask : await
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		// Reset values, read-only reserved bit, unmapped place
		bus(0, ADDR_CONTROL, CONTROL_RESET);
		bus(1, 3'h7, 8'hFF);
		bus(0, 3'h7, 8'h00);
		bus(1, ADDR_CONTROL, 8'h00);
		bus(0, ADDR_CONTROL, CONTROL_RESET);
		bus(0, ADDR_DATA, DATA_RESET);
		bus(1, ADDR_IRQ_MASK, 8'h01);
		// Both formats, both ninth-bit levels, late write refused
		for (int k = 0; k < 4; k++) begin
			nine = k[1];
			d = 8'($random(seed));
			fr_q.push_back({1'b1, k[1] ? k[0] : 1'b1, d});
			bus(1, ADDR_CONTROL, {k[1], 1'b1, 2'b00, k[0], 3'b000});
			bus(1, ADDR_DATA, d);
			bus(1, ADDR_DATA, ~d);
			idle(1);
			await(irq_o, 1'b1);
			`CHK({tx_o, tx_busy_o}, 2'b11)
			await(tx_busy_o, 1'b0);
			bus(1, ADDR_IRQ_MASK, 8'h00);
			bus(0, ADDR_CONTROL, {k[1], 1'b1, 2'b00, k[0], 3'b010});
			bus(0, ADDR_IRQ_STATUS, 8'h01);
			bus(1, ADDR_IRQ_MASK, 8'h01);
			idle(1);
			#1 `CHK(irq_o, 1'b1)
			bus(1, ADDR_CONTROL, 8'h40);
			bus(1, ADDR_IRQ_STATUS, 8'h01);
			idle(1);
			#1 `CHK(irq_o, 1'b0)
		end
		// Receive table: keep flag, enable, format, check, checked bit
		bus(1, ADDR_IRQ_MASK, 8'h02);
		flag = 1'b0;
		r9 = 1'b0;
		foreach (cases[j]) begin
			c = cases[j];
			d = 8'($random(seed));
			if (!c[4]) begin
				bus(1, ADDR_IRQ_STATUS, 8'h02);
				flag = 1'b0;
			end
			bus(1, ADDR_CONTROL, {c[2], 1'b1, c[1], c[3], 1'b0, r9, 1'b0, flag});
			frame <= {1'b1, c[0], d, 1'b0};
			len <= c[2] ? 4'hB : 4'hA;
			go <= 1'b1;
			idle(1);
			go <= 1'b0;
			idle(2);
			await(busy, 1'b0);
			idle(40);
			acc = c[3] && !flag && (!c[1] || c[0]);
			if (acc) begin
				latch = d;
				r9 = c[0];
				flag = 1'b1;
			end
			#1 `CHK(irq_o, flag)
			bus(0, ADDR_CONTROL, {c[2], 1'b1, c[1], c[3], 1'b0, r9, 1'b0, flag});
			bus(0, ADDR_DATA, latch);
		end
		idle(2);
		results();
	end
endmodule : tb_top
